// ===== rtl/rpc_pkg.sv
// Package of constants and types for the cascaded RGB PWM driver
package rpc_pkg;
   // Clock rate and idle threshold
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned IDLE_TIME_US   = 500;
   localparam int unsigned IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ + 1;
   localparam int unsigned IDLE_CNT_W     = 18;
   // Frame layout
   localparam int unsigned CHAN_BITS      = 8;
   localparam int unsigned CHAN_COUNT     = 3;
   localparam int unsigned FRAME_BITS     = CHAN_BITS * CHAN_COUNT;
   localparam int unsigned RED_POS        = 16;
   localparam int unsigned GREEN_POS      = 8;
   localparam int unsigned BLUE_POS       = 0;
   localparam int unsigned BIT_CNT_W      = 5;
   // Free-running PWM step divider (one step every PWM_DIV cycles)
   // A short step keeps the period at 1024 cycles; raise it for a slower
   // refresh, since nothing on the link depends on the step length
   localparam int unsigned PWM_DIV        = 4;
   localparam int unsigned PWM_DIV_W      = 9;
   // Values after reset, and the frame FIFO depth
   localparam logic [7:0]  GRAY_RESET     = 8'h00;
   localparam int unsigned FIFO_DEPTH     = 4;

   // One latched frame of gray levels
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } rpc_gray_s;

   // Receiver state
   typedef enum logic [0:0] {
      RX_SHIFT,
      RX_RELAY
   } rpc_rx_e;
endpackage : rpc_pkg

// ===== rtl/rpc_fifo.sv
// Small valid/ready FIFO that carries latched frames to the PWM stage
module rpc_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic [WIDTH-1:0] out_reg;
   logic             vld_reg;

   wire push     = in_valid && in_ready;
   wire pop      = vld_reg && out_ready;
   wire have     = cnt_reg != '0;
   // Refill the output register when empty or being drained
   wire load     = have && (!vld_reg || pop);
   wire [AW:0] one = {{AW{1'b0}}, 1'b1};

   assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
   assign out_data  = out_reg;
   assign out_valid = vld_reg;

   // Storage; read data leaves through a register
   always_ff @(posedge clock) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
         vld_reg <= 1'b0;
         out_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= AW'(wr_reg + 1'b1);
         end
         if (load) begin
            rd_reg  <= AW'(rd_reg + 1'b1);
            out_reg <= mem_reg[rd_reg];
         end
         if (load) begin
            vld_reg <= 1'b1;
         end else if (pop) begin
            vld_reg <= 1'b0;
         end
         cnt_reg <= cnt_reg + (push ? one : '0) - (load ? one : '0);
      end
   end
endmodule : rpc_fifo

// ===== rtl/rpc_driver.sv
// Cascadable three-channel gray-scale PWM driver with serial input
// How it works
// - Serial clock low for more than 500 us resets the receiver and latches the frame.
// - After 24 rising clock edges the block relays clock and data to the next device.
// - A frame is three 8-bit gray words, 24 bits in all, one per channel.
// - Bits arrive MSB first, red MSB first and blue LSB last.
// - Each channel duty cycle is its gray value over 256.
// - Zero keeps a channel off; all ones keeps it on for 255 of 256 steps.
// - Polarity select low inverts all three drives; high keeps them normal.
// - New gray values reach the comparators only at the end of a PWM period.
module rpc_driver (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic serial_clock_in,
   input  wire logic serial_data_in,
   input  wire logic polarity_select,
   output logic      serial_data_out,
   output logic      buffered_clock_out,
   output logic      red_channel_drive,
   output logic      green_channel_drive,
   output logic      blue_channel_drive,
   output logic      frame_overflow
);
   import rpc_pkg::*;

   // Synchronisers: first stage read only by second stage
   logic [1:0] ck_sync_reg;
   logic [1:0] dt_sync_reg;
   logic [1:0] pol_sync_reg;
   logic       ck_last_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ck_sync_reg  <= 2'h0;
         dt_sync_reg  <= 2'h0;
         pol_sync_reg <= 2'h3;
         ck_last_reg  <= 1'b0;
      end else begin
         ck_sync_reg  <= {ck_sync_reg[0], serial_clock_in};
         dt_sync_reg  <= {dt_sync_reg[0], serial_data_in};
         pol_sync_reg <= {pol_sync_reg[0], polarity_select};
         ck_last_reg  <= ck_sync_reg[1];
      end
   end

   wire ck_s    = ck_sync_reg[1];
   wire dt_s    = dt_sync_reg[1];
   wire pol_s   = pol_sync_reg[1];
   wire ck_rise = ck_s && !ck_last_reg;

   // Receiver: shift register, bit count, idle timer
   rpc_rx_e                 rx_state_reg;
   rpc_rx_e                 rx_state_next;
   logic [FRAME_BITS-1:0]   shift_reg;
   logic [BIT_CNT_W-1:0]    bit_cnt_reg;
   logic [IDLE_CNT_W-1:0]   idle_cnt_reg;
   logic                    latched_reg;

   wire idle_hit  = idle_cnt_reg == IDLE_CNT_W'(IDLE_CYCLES);
   // Latch once per idle period and only if some bits arrived
   wire do_latch  = idle_hit && !latched_reg && bit_cnt_reg != '0;
   wire frame_full = bit_cnt_reg == BIT_CNT_W'(FRAME_BITS);
   wire shifting  = rx_state_reg == RX_SHIFT && ck_rise;

   // Relay starts once the 24th clock is low again, so the high tail of
   // that clock is never passed on as a false edge to the next device
   always_comb begin
      rx_state_next = rx_state_reg;
      unique case (rx_state_reg)
         RX_SHIFT: begin
            if (frame_full && !ck_s) begin
               rx_state_next = RX_RELAY;
            end
         end
         RX_RELAY: begin
            rx_state_next = RX_RELAY;
         end
      endcase
      if (idle_hit) begin
         rx_state_next = RX_SHIFT;
      end
   end

   // Idle timer counts while the clock stays low, saturating
   always_ff @(posedge clock) begin
      if (!rstn) begin
         idle_cnt_reg <= '0;
         latched_reg  <= 1'b0;
      end else begin
         if (ck_s) begin
            idle_cnt_reg <= '0;
            latched_reg  <= 1'b0;
         end else if (!idle_hit) begin
            idle_cnt_reg <= IDLE_CNT_W'(idle_cnt_reg + 1'b1);
         end else begin
            latched_reg  <= 1'b1;
         end
      end
   end

   // Shift in MSB first; red enters first, blue LSB last
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rx_state_reg <= RX_SHIFT;
         shift_reg    <= '0;
         bit_cnt_reg  <= '0;
      end else begin
         rx_state_reg <= rx_state_next;
         if (idle_hit) begin
            bit_cnt_reg <= '0;
         end else if (shifting) begin
            shift_reg   <= {shift_reg[FRAME_BITS-2:0], dt_s};
            bit_cnt_reg <= BIT_CNT_W'(bit_cnt_reg + 1'b1);
         end
      end
   end

   // Relay outputs follow the synchronised inputs while relaying
   always_ff @(posedge clock) begin
      if (!rstn) begin
         serial_data_out    <= 1'b0;
         buffered_clock_out <= 1'b0;
      end else begin
         serial_data_out    <= rx_state_reg == RX_RELAY && dt_s;
         buffered_clock_out <= rx_state_reg == RX_RELAY && ck_s;
      end
   end

   // Frame unpacking: green holds the middle byte
   rpc_gray_s frame_in;
   assign frame_in.red   = shift_reg[RED_POS +: CHAN_BITS];
   assign frame_in.green = shift_reg[GREEN_POS +: CHAN_BITS];
   assign frame_in.blue  = shift_reg[BLUE_POS +: CHAN_BITS];

   // Frame FIFO; a full FIFO drops the frame and flags it
   logic      fifo_in_ready;
   logic [FRAME_BITS-1:0] fifo_out_data;
   logic      fifo_out_valid;
   wire       period_end;

   rpc_fifo #(
      .WIDTH (FRAME_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .in_data   (frame_in),
      .in_valid  (do_latch),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (period_end)
   );

   // Sticky overflow until reset: a latched frame the FIFO refused
   always_ff @(posedge clock) begin
      if (!rstn) begin
         frame_overflow <= 1'b0;
      end else if (do_latch && !fifo_in_ready) begin
         frame_overflow <= 1'b1;
      end
   end

   // PWM step enable from a divider; steps run free of the link
   logic [PWM_DIV_W-1:0] div_reg;
   logic [7:0]           step_reg;
   wire                  step_en = div_reg == PWM_DIV_W'(PWM_DIV - 1);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         div_reg  <= '0;
         step_reg <= 8'h00;
      end else begin
         div_reg <= step_en ? '0 : PWM_DIV_W'(div_reg + 1'b1);
         if (step_en) begin
            step_reg <= step_reg + 8'h01;
         end
      end
   end

   // Period ends on the last step; the FIFO drains only here
   assign period_end = step_en && step_reg == 8'hFF;

   rpc_gray_s active_reg;
   rpc_gray_s active_next;
   assign active_next = (period_end && fifo_out_valid) ?
                        rpc_gray_s'(fifo_out_data) : active_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         active_reg <= {GRAY_RESET, GRAY_RESET, GRAY_RESET};
      end else begin
         active_reg <= active_next;
      end
   end

   // Comparators: on while step below gray, so 0 is off, FF is 255/256
   wire [CHAN_COUNT-1:0] on_raw;
   wire [CHAN_COUNT-1:0] on_drv;
   wire [FRAME_BITS-1:0] act_bits = active_next;

   genvar ch;
   generate
      for (ch = 0; ch < CHAN_COUNT; ch++) begin : g_cmp
         // Step is the one about to show, keeping drive aligned to load
         assign on_raw[ch] = (step_en ? step_reg + 8'h01 : step_reg) <
                             act_bits[ch*CHAN_BITS +: CHAN_BITS];
         assign on_drv[ch] = on_raw[ch] ^ !pol_s;
      end
   endgenerate

   // Drive outputs registered
   always_ff @(posedge clock) begin
      if (!rstn) begin
         red_channel_drive   <= 1'b0;
         green_channel_drive <= 1'b0;
         blue_channel_drive  <= 1'b0;
      end else begin
         red_channel_drive   <= on_drv[2];
         green_channel_drive <= on_drv[1];
         blue_channel_drive  <= on_drv[0];
      end
   end
endmodule : rpc_driver

// ===== testbench/rpc_driver_monitor.sv
// Checker on the driver pins: relay start and PWM step timing
module rpc_driver_monitor (
   input wire logic clock,
   input wire logic rstn,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   input wire logic polarity_select,
   input wire logic serial_data_out,
   input wire logic buffered_clock_out,
   input wire logic red_channel_drive,
   input wire logic green_channel_drive,
   input wire logic blue_channel_drive,
   input wire logic frame_overflow
);
   timeunit 1ns;
   timeprecision 1ps;
   import rpc_pkg::*;
   logic        sc_q, red_q, shifting;
   logic [5:0]  edge_cnt;
   logic [17:0] low_cnt;
   logic [19:0] hi_cnt, gap_cnt;
   // Pin edges counted raw; idle clear lands early, so zero is left out
   assign shifting = (edge_cnt != '0) && (edge_cnt < 6'h18);
   // Edge and idle counters; long cascades would wrap the 6-bit count
   always_ff @(posedge clock) begin
      sc_q <= serial_clock_in;
      if (!rstn || serial_clock_in) low_cnt <= '0;
      else if (low_cnt != 18'(IDLE_CYCLES)) low_cnt <= low_cnt + 18'h1;
      if (!rstn || low_cnt == 18'(IDLE_CYCLES)) edge_cnt <= '0;
      else if (serial_clock_in && !sc_q) edge_cnt <= edge_cnt + 6'h1;
   end
   // Run lengths; a polarity change voids them
   always_ff @(posedge clock) begin
      red_q <= red_channel_drive;
      if (!rstn || !green_channel_drive || !polarity_select) hi_cnt <= '0;
      else hi_cnt <= hi_cnt + 20'h1;
      if (!rstn || !polarity_select) gap_cnt <= '0;
      else if (red_channel_drive && !red_q) gap_cnt <= 20'h1;
      else if (gap_cnt != '0) gap_cnt <= gap_cnt + 20'h1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Any relayed clock rising edge
   sequence relay_rise;
      $rose(buffered_clock_out);
   endsequence
   chk_relay_late: assert property (relay_rise |-> edge_cnt >= 6'h19)
      else $error("relay began before the frame was full");
   chk_shift_quiet: assert property (shifting |-> !buffered_clock_out)
      else $error("clock relayed while shifting");
   chk_data_quiet: assert property (shifting |-> !serial_data_out)
      else $error("data relayed while shifting");
   chk_clock_follow: assert property (
      relay_rise |-> $past(serial_clock_in, 3))
      else $error("relayed clock without input clock");
   chk_data_follow: assert property (
      relay_rise |-> serial_data_out == $past(serial_data_in, 3))
      else $error("relayed data differs from input");
   chk_step_width: assert property (
      $fell(green_channel_drive) && polarity_select
         |-> hi_cnt % PWM_DIV == 0)
      else $error("high time not a whole number of steps");
   chk_full_scale: assert property (
      polarity_select |-> hi_cnt <= 255 * PWM_DIV)
      else $error("channel high for more than 255 steps");
   chk_period_edge: assert property (
      $rose(red_channel_drive) && gap_cnt != '0
         |-> gap_cnt % (256 * PWM_DIV) == 0)
      else $error("period start moved off the period grid");
endmodule : rpc_driver_monitor

bind rpc_driver rpc_driver_monitor i_rpc_driver_monitor (
   .clock, .rstn, .serial_clock_in, .serial_data_in, .polarity_select,
   .serial_data_out, .buffered_clock_out, .red_channel_drive,
   .green_channel_drive, .blue_channel_drive, .frame_overflow
);

// ===== testbench/rpc_link_ctl.sv
// Upstream controller model that clocks gray frames into the driver
module rpc_link_ctl (
   output logic serial_clock_in,
   output logic serial_data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock idles low between frames so the driver latches
   initial begin
      serial_clock_in = 1'b0;
      serial_data_in = 1'b0;
   end
   // Sends n bits MSB first; data moves only while the clock is low
   task automatic send(input logic [31:0] word, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = word[i];
         #62.5;
         serial_clock_in = 1'b1;
         #62.5;
         serial_clock_in = 1'b0;
      end
      serial_data_in = ~serial_data_in; // Released line shows no stale bit
   endtask : send
endmodule : rpc_link_ctl

// ===== testbench/rpc_driver_tb.sv
// Self-checking bench for the cascaded RGB PWM driver
module rpc_driver_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rpc_pkg::*;
   logic       clock = 1'b0;
   logic       rstn = 1'b0;
   logic       polarity_select = 1'b1;
   logic       serial_clock_in, serial_data_in, serial_data_out;
   logic       buffered_clock_out, red_channel_drive, green_channel_drive;
   logic       blue_channel_drive, frame_overflow;
   logic [7:0] red, extra;
   int         seed = 30;
   int         mismatches = 0;
   int         check_count = 0;
   int         hi_r, hi_g, hi_b;
   always #2 clock = ~clock;
   rpc_link_ctl i_rpc_link_ctl (.serial_clock_in, .serial_data_in);
   rpc_driver i_rpc_driver (
      .clock, .rstn, .serial_clock_in, .serial_data_in, .polarity_select,
      .serial_data_out, .buffered_clock_out, .red_channel_drive,
      .green_channel_drive, .blue_channel_drive, .frame_overflow
   );
   task automatic end_of_test;
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic check_level(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: level %b, expected %b", $time, got, exp);
      end
   endtask : check_level
   task automatic check_total(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         mismatches++;
         $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask : check_total
   // High cycles of one PWM period for a gray value
   function automatic int high_cycles(input logic [7:0] gray);
      return int'(gray) * int'(PWM_DIV);
   endfunction : high_cycles
   function automatic logic probe(input int which);
      return which == 0 ? serial_clock_in : red_channel_drive;
   endfunction : probe
   // Bounded wait; running out ends the run as a failure
   task automatic wait_for(input int which, input logic lvl, input int lim);
      for (int i = 0; i < lim && probe(which) !== lvl; i++) @(negedge clock);
      if (probe(which) !== lvl) begin
         mismatches++;
         $display("Error at %0t: wait ran out", $time);
         end_of_test;
      end
   endtask : wait_for
   // Frame, relay, latch, duty per channel, then inverted polarity
   initial begin
      red = 8'($random(seed)) | 8'h01;
      extra = 8'($random(seed));
      repeat (6) @(negedge clock);
      rstn = 1'b1;
      repeat (4) @(negedge clock);
      fork
         i_rpc_link_ctl.send({red, 8'hFF, 8'h00, extra}, 32);
         for (int b = 0; b < 32; b++) begin
            wait_for(0, 1'b1, 100);
            repeat (8) @(negedge clock);
            check_level(buffered_clock_out, b >= 24);
            check_level(serial_data_out,
               b >= 24 ? serial_data_in : 1'b0);
            wait_for(0, 1'b0, 100);
         end
      join
      wait_for(1, 1'b1, 140000);
      hi_r = 0;
      hi_g = 0;
      hi_b = 0;
      repeat (256 * PWM_DIV) begin
         hi_r += int'(red_channel_drive === 1'b1);
         hi_g += int'(green_channel_drive === 1'b1);
         hi_b += int'(blue_channel_drive === 1'b1);
         @(negedge clock);
      end
      check_total(hi_r, high_cycles(red));
      check_total(hi_g, high_cycles(8'hFF));
      check_total(hi_b, 0);
      check_level(frame_overflow, 1'b0);
      repeat (4) @(negedge clock);
      polarity_select = 1'b0;
      repeat (8) @(negedge clock);
      repeat (40) begin
         check_level(blue_channel_drive, 1'b1);
         @(negedge clock);
      end
      end_of_test;
   end
endmodule : rpc_driver_tb
